// ===== rtl/xarf_defs.vh
`ifndef XARF_DEFS_VH
`define XARF_DEFS_VH
// ----------------------------------------
// Widths
// ----------------------------------------
`define XARF_GPR_W      32
`define XARF_SEG_W      16
`define XARF_FP_W       80
`define XARF_MM_W       64
`define XARF_FPW_W      16
// ----------------------------------------
// General register access sizes
// ----------------------------------------
`define XARF_SZ_DWORD   2'h0
`define XARF_SZ_WORD    2'h1
`define XARF_SZ_BLOW    2'h2
`define XARF_SZ_BHIGH   2'h3
// ----------------------------------------
// Floating-point word selects
// ----------------------------------------
`define XARF_FW_STATUS  2'h0
`define XARF_FW_CONTROL 2'h1
`define XARF_FW_TAG     2'h2
// ----------------------------------------
// Reset values (none documented, zero chosen)
// ----------------------------------------
`define XARF_RST_GPR    32'h00000000
`define XARF_RST_SEG    16'h0000
`define XARF_RST_FP     80'h0
`define XARF_RST_FPW    16'h0000
`define XARF_RST_IP     32'h00000000
`endif

// ===== rtl/xarf_register_file.v
`timescale 1ns/100ps
`include "xarf_defs.vh"
// Operation
// [RULE1] Eight 32-bit general registers hold integers or pointers.
// [RULE2] First four registers expose a 16-bit alias on their low half.
// [RULE3] Those 16-bit aliases split into high-byte and low-byte 8-bit aliases.
// [RULE4] Last four registers offer only a 16-bit low alias, no byte aliases.
// [RULE5] Aliases share storage with the parent register.
// [RULE6] General registers hold byte, word, doubleword and quadword integers.
// [RULE7] Six 16-bit segment registers: code, stack and four data.
// [RULE8] Instruction pointer is 32 or 16 bits, no direct software write.
// [RULE9] Eight floating-point registers, each 80 bits wide.
// [RULE10] A 16-bit status word reports floating-point unit state.
// [RULE11] Control word selects options; tag word records each stack register state.
// [RULE12] Eight 64-bit multimedia registers share floating-point storage.
// [RULE13] Multimedia registers carry packed bytes, one quadword or two doublewords.
// [RULE14] Software leaves reserved register areas unmodified.
// [RULE15] Narrow alias writes change only the aliased bits; multimedia writes also set bits 79:64 to all ones.
module xarf_register_file (
  // Clock and reset
  input  wire         clock,
  input  wire         rst_b,
  // General register write
  input  wire         gprWrEn,
  input  wire [2:0]   gprWrIdx,
  input  wire [1:0]   gprWrSize,
  input  wire [31:0]  gprWrData,
  // Quadword write to a register pair (low index, low index + 1)
  input  wire         gprPairWrEn,
  input  wire [2:0]   gprPairWrIdx,
  input  wire [63:0]  gprPairWrData,
  // General register read
  input  wire [2:0]   gprRdIdx,
  input  wire [1:0]   gprRdSize,
  output reg  [31:0]  gprRdData,
  output reg  [63:0]  gprPairRdData,
  // Segment registers
  input  wire         segWrEn,
  input  wire [2:0]   segWrIdx,
  input  wire [15:0]  segWrData,
  input  wire [2:0]   segRdIdx,
  output reg  [15:0]  segRdData,
  // Instruction pointer, pipeline advance only
  input  wire         ipLoadEn,
  input  wire [31:0]  ipNext,
  input  wire         ipMode16,
  output reg  [31:0]  instrPointerWide,
  output reg  [15:0]  instrPointerNarrow,
  // Floating-point stack and multimedia view
  input  wire         fpWrEn,
  input  wire [2:0]   fpWrIdx,
  input  wire [79:0]  fpWrData,
  input  wire         mmWrEn,
  input  wire [2:0]   mmWrIdx,
  input  wire [63:0]  mmWrData,
  input  wire [2:0]   fpRdIdx,
  output reg  [79:0]  fpRdData,
  output reg  [63:0]  mmRdData,
  // Floating-point control, status and tag words
  input  wire         fpwWrEn,
  input  wire [1:0]   fpwWrSel,
  input  wire [15:0]  fpwWrData,
  input  wire [1:0]   fpwRdSel,
  output reg  [15:0]  fpwRdData
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [31:0] gprReg [0:7];  // [RULE1]
  reg [15:0] segReg [0:5];  // [RULE7]
  reg [79:0] fpReg  [0:7];  // [RULE9]
  reg [15:0] fpStatusReg;
  reg [15:0] fpControlReg;
  reg [15:0] fpTagReg;
  reg [31:0] ipReg;
  integer    gprLoop;
  integer    segLoop;
  integer    fpLoop;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Merge a sized write into the old value; byte aliases only on 0..3
  function [31:0] xarf_merge;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [1:0]  size;
    input [2:0]  idx;
    begin
      case (size)
        `XARF_SZ_DWORD: xarf_merge = newVal;
        `XARF_SZ_WORD:  xarf_merge = {oldVal[31:16], newVal[15:0]};  // [RULE2] [RULE4] [RULE15]
        `XARF_SZ_BLOW:  xarf_merge = idx[2] ? oldVal :
                                     {oldVal[31:8], newVal[7:0]};  // [RULE3] [RULE15]
        `XARF_SZ_BHIGH: xarf_merge = idx[2] ? oldVal :
                                     {oldVal[31:16], newVal[7:0], oldVal[7:0]};  // [RULE3]
        default:        xarf_merge = oldVal;
      endcase
    end
  endfunction

  // Extract a sized read, zero extended; byte aliases absent on 4..7
  function [31:0] xarf_extract;
    input [31:0] val;
    input [1:0]  size;
    input [2:0]  idx;
    begin
      case (size)
        `XARF_SZ_DWORD: xarf_extract = val;
        `XARF_SZ_WORD:  xarf_extract = {16'h0000, val[15:0]};  // [RULE2] [RULE4]
        `XARF_SZ_BLOW:  xarf_extract = idx[2] ? 32'h00000000 : {24'h000000, val[7:0]};
        `XARF_SZ_BHIGH: xarf_extract = idx[2] ? 32'h00000000 : {24'h000000, val[15:8]};
        default:        xarf_extract = 32'h00000000;
      endcase
    end
  endfunction

  // ----------------------------------------
  // General registers, single storage for all aliases
  // ----------------------------------------
  // Sized write beats pair write on the same register; pipeline should avoid both
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (gprLoop = 0; gprLoop < 8; gprLoop = gprLoop + 1) begin
        gprReg[gprLoop] <= `XARF_RST_GPR;
      end
    end else begin
      if (gprPairWrEn) begin  // [RULE6]
        gprReg[gprPairWrIdx]          <= gprPairWrData[31:0];
        gprReg[gprPairWrIdx + 3'h1]   <= gprPairWrData[63:32];
      end
      if (gprWrEn) begin
        gprReg[gprWrIdx] <= xarf_merge(gprReg[gprWrIdx], gprWrData,
                                       gprWrSize, gprWrIdx);  // [RULE5] [RULE15]
      end
    end
  end

  // ----------------------------------------
  // Segment registers: 0 code, 1 stack, 2..5 data
  // ----------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (segLoop = 0; segLoop < 6; segLoop = segLoop + 1) begin
        segReg[segLoop] <= `XARF_RST_SEG;
      end
    end else if (segWrEn && segWrIdx < 3'h6) begin  // [RULE7]
      segReg[segWrIdx] <= segWrData;
    end
  end

  // ----------------------------------------
  // Instruction pointer
  // ----------------------------------------
  // Only the pipeline advance path exists; no software write port
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ipReg <= `XARF_RST_IP;
    end else if (ipLoadEn) begin
      ipReg <= ipMode16 ? {16'h0000, ipNext[15:0]} : ipNext;  // [RULE8]
    end
  end

  // ----------------------------------------
  // Floating-point stack, multimedia alias on mantissa bits
  // ----------------------------------------
  // Multimedia write also sets the exponent field to all ones
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (fpLoop = 0; fpLoop < 8; fpLoop = fpLoop + 1) begin
        fpReg[fpLoop] <= `XARF_RST_FP;
      end
    end else begin
      if (fpWrEn) begin
        fpReg[fpWrIdx] <= fpWrData;  // [RULE9]
      end
      if (mmWrEn) begin
        fpReg[mmWrIdx] <= {16'hffff, mmWrData};  // [RULE12] [RULE13]
      end
    end
  end

  // ----------------------------------------
  // Floating-point control, status and tag words
  // ----------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fpStatusReg  <= `XARF_RST_FPW;
      fpControlReg <= `XARF_RST_FPW;
      fpTagReg     <= `XARF_RST_FPW;
    end else if (fpwWrEn) begin
      case (fpwWrSel)
        `XARF_FW_STATUS:  fpStatusReg  <= fpwWrData;  // [RULE10]
        `XARF_FW_CONTROL: fpControlReg <= fpwWrData;  // [RULE11]
        `XARF_FW_TAG:     fpTagReg     <= fpwWrData;  // [RULE11]
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registered read ports
  // ----------------------------------------
  // One cycle read latency keeps all data outputs from flip-flops
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gprRdData          <= 32'h00000000;
      gprPairRdData      <= 64'h0;
      segRdData          <= 16'h0000;
      instrPointerWide   <= 32'h00000000;
      instrPointerNarrow <= 16'h0000;
      fpRdData           <= 80'h0;
      mmRdData           <= 64'h0;
      fpwRdData          <= 16'h0000;
    end else begin
      gprRdData          <= xarf_extract(gprReg[gprRdIdx], gprRdSize, gprRdIdx);  // [RULE5]
      gprPairRdData      <= {gprReg[gprRdIdx + 3'h1], gprReg[gprRdIdx]};  // [RULE6]
      segRdData          <= (segRdIdx < 3'h6) ? segReg[segRdIdx] : 16'h0000;
      instrPointerWide   <= ipReg;
      instrPointerNarrow <= ipReg[15:0];  // [RULE8]
      fpRdData           <= fpReg[fpRdIdx];
      mmRdData           <= fpReg[fpRdIdx][63:0];  // [RULE12]
      case (fpwRdSel)
        `XARF_FW_STATUS:  fpwRdData <= fpStatusReg;
        `XARF_FW_CONTROL: fpwRdData <= fpControlReg;
        `XARF_FW_TAG:     fpwRdData <= fpTagReg;
        default:          fpwRdData <= 16'h0000;
      endcase
    end
  end

endmodule

// ===== test/xarf_pipe_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Pipeline advance model
// ----------------------------------------
module xarf_pipe_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Bench control
  input  wire logic        run,
  input  wire logic        mode16,
  // Pointer advance
  output logic             ipLoadEn,
  output logic      [31:0] ipNext,
  output logic             ipMode16
);
  // Steps by four per cycle; only path that moves the pointer
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ipLoadEn <= 1'b0;
      ipNext   <= 32'h0001fff8;  // Upper half set so 16-bit truncation shows
      ipMode16 <= 1'b0;
    end else begin
      ipLoadEn <= run;
      ipMode16 <= mode16;
      if (run) ipNext <= ipNext + 32'h4;
    end
  end
endmodule

// ===== test/xarf_register_file_properties.sv
`timescale 1ns/100ps
`include "xarf_defs.vh"
module xarf_checker (
  // Clock and reset
  input wire        clock,
  input wire        rst_b,
  // Watched ports
  input wire        ipLoadEn,
  input wire [31:0] ipNext,
  input wire        ipMode16,
  input wire [31:0] instrPointerWide,
  input wire [15:0] instrPointerNarrow,
  input wire        segWrEn,
  input wire [2:0]  segWrIdx,
  input wire [15:0] segWrData,
  input wire [2:0]  segRdIdx,
  input wire [15:0] segRdData,
  input wire [1:0]  fpwRdSel,
  input wire [15:0] fpwRdData,
  input wire [79:0] fpRdData,
  input wire [63:0] mmRdData,
  input wire [2:0]  gprRdIdx,
  input wire [1:0]  gprRdSize,
  input wire [31:0] gprRdData
);
  // One domain, so clock and reset given once
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  ip_wide_load_a:
    assert property (ipLoadEn && !ipMode16 |-> ##2 instrPointerWide == $past(ipNext, 2))
    else $error("wide pointer load wrong");
  ip_narrow_load_a:
    assert property (ipLoadEn && ipMode16 |-> ##2 instrPointerWide == {16'h0, $past(ipNext[15:0], 2)})
    else $error("narrow pointer load wrong");
  ip_hold_a:
    assert property (!ipLoadEn ##1 !ipLoadEn |=> $stable(instrPointerWide))
    else $error("pointer moved without load");
  ip_alias_a:
    assert property (instrPointerNarrow == instrPointerWide[15:0])
    else $error("narrow pointer differs");
  seg_write_a:
    assert property (segWrEn && segWrIdx < 3'h6 ##1 segRdIdx == $past(segWrIdx) && !segWrEn
      |=> segRdData == $past(segWrData, 2))
    else $error("segment write lost");
  seg_unused_a:
    assert property (segRdIdx > 3'h5 |=> segRdData == 16'h0)
    else $error("missing segment read nonzero");
  fpw_unused_a:
    assert property (fpwRdSel == 2'h3 |=> fpwRdData == 16'h0)
    else $error("unused word select nonzero");
  mm_alias_a:
    assert property (mmRdData == fpRdData[63:0])
    else $error("multimedia view differs");
  gpr_nobyte_a:
    assert property (gprRdIdx[2] && gprRdSize[1] |=> gprRdData == 32'h0)
    else $error("byte read on upper register");
  gpr_hibyte_a:
    assert property (gprRdSize == `XARF_SZ_BHIGH |=> gprRdData[31:8] == 24'h0)
    else $error("high byte not zero extended");
endmodule

// ===== test/xarf_register_file_tb_top.sv
`timescale 1ns/100ps
`include "xarf_defs.vh"
module xarf_register_file_tb_top;
  // Stimulus and observed signals
  logic        clock = 0, rst_b = 0, run = 0, mode16 = 0, ipLoadEn, ipMode16;
  logic        gprWrEn = 0, gprPairWrEn = 0, segWrEn = 0, fpWrEn = 0, mmWrEn = 0, fpwWrEn = 0;
  logic [2:0]  gprWrIdx = 0, gprPairWrIdx = 0, gprRdIdx = 0, segWrIdx = 0, segRdIdx = 0;
  logic [2:0]  fpWrIdx = 0, mmWrIdx = 0, fpRdIdx = 0;
  logic [1:0]  gprWrSize = 0, gprRdSize = 0, fpwWrSel = 0, fpwRdSel = 0;
  logic [15:0] segWrData = 0, fpwWrData = 0, segRdData, fpwRdData, instrPointerNarrow;
  logic [31:0] gprWrData = 0, gprRdData, ipNext, instrPointerWide;
  logic [63:0] gprPairWrData = 0, mmWrData = 0, gprPairRdData, mmRdData;
  logic [79:0] fpWrData = 0, fpRdData;
  int          num_errors = 0, num_checks = 0;
  always #10 clock = ~clock;
  xarf_register_file u_dut (
    .clock(clock), .rst_b(rst_b),
    .gprWrEn(gprWrEn), .gprWrIdx(gprWrIdx), .gprWrSize(gprWrSize), .gprWrData(gprWrData),
    .gprPairWrEn(gprPairWrEn), .gprPairWrIdx(gprPairWrIdx), .gprPairWrData(gprPairWrData),
    .gprRdIdx(gprRdIdx), .gprRdSize(gprRdSize), .gprRdData(gprRdData),
    .gprPairRdData(gprPairRdData),
    .segWrEn(segWrEn), .segWrIdx(segWrIdx), .segWrData(segWrData), .segRdIdx(segRdIdx),
    .segRdData(segRdData),
    .ipLoadEn(ipLoadEn), .ipNext(ipNext), .ipMode16(ipMode16),
    .instrPointerWide(instrPointerWide), .instrPointerNarrow(instrPointerNarrow),
    .fpWrEn(fpWrEn), .fpWrIdx(fpWrIdx), .fpWrData(fpWrData),
    .mmWrEn(mmWrEn), .mmWrIdx(mmWrIdx), .mmWrData(mmWrData),
    .fpRdIdx(fpRdIdx), .fpRdData(fpRdData), .mmRdData(mmRdData),
    .fpwWrEn(fpwWrEn), .fpwWrSel(fpwWrSel), .fpwWrData(fpwWrData),
    .fpwRdSel(fpwRdSel), .fpwRdData(fpwRdData)
  );
  xarf_pipe_model u_pipe (
    .clock(clock), .rst_b(rst_b), .run(run), .mode16(mode16),
    .ipLoadEn(ipLoadEn), .ipNext(ipNext), .ipMode16(ipMode16)
  );
  // Inputs move a fixed 1 ns after each rising edge
  task step;
    @(posedge clock);
    #1;
  endtask
  task chk(input string n, input logic [79:0] e, input logic [79:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Write is left enabled so back-to-back calls never toggle twice
  task gw(input logic [2:0] i, input logic [1:0] s, input logic [31:0] d);
    {gprWrEn, gprWrIdx, gprWrSize, gprWrData} = {1'b1, i, s, d};
    step;
  endtask
  task gr(input logic [2:0] i, input logic [1:0] s, input logic [31:0] e);
    {gprWrEn, gprRdIdx, gprRdSize} = {1'b0, i, s};
    step;
    chk("gprRdData", {48'h0, e}, {48'h0, gprRdData});
  endtask
  task test_gpr;
    gw(3'h0, `XARF_SZ_DWORD, 32'h12345678);
    gw(3'h0, `XARF_SZ_BHIGH, 32'h000000ab);
    gr(3'h0, `XARF_SZ_WORD, 32'h0000ab78);
    gr(3'h0, `XARF_SZ_BHIGH, 32'h000000ab);
    gw(3'h0, `XARF_SZ_BLOW, 32'hffffffcd);
    gr(3'h0, `XARF_SZ_DWORD, 32'h1234abcd);
    gw(3'h5, `XARF_SZ_DWORD, 32'hdeadbeef);
    gw(3'h5, `XARF_SZ_BLOW, 32'h00000011);
    gr(3'h5, `XARF_SZ_WORD, 32'h0000beef);
    gr(3'h5, `XARF_SZ_BLOW, 32'h00000000);
    gr(3'h5, `XARF_SZ_BHIGH, 32'h00000000);
    {gprPairWrEn, gprPairWrIdx, gprPairWrData} = {1'b1, 3'h7, 64'h0123456789abcdef};
    step;
    gprPairWrEn = 0;
    gr(3'h7, `XARF_SZ_DWORD, 32'h89abcdef);
    chk("gprPairRdData", {16'h0, 64'h0123456789abcdef}, {16'h0, gprPairRdData});
  endtask
  task test_words;
    logic [15:0] fpwExp;
    for (int i = 0; i < 8; i++) begin
      {segWrEn, segWrIdx, segWrData, fpwWrEn} = {1'b1, i[2:0], 16'h1000 + i[15:0], 1'b1};
      {fpwWrSel, fpwWrData} = {i[1:0], 16'ha5a0 + i[15:0]};
      step;
    end
    {segWrEn, fpwWrEn} = 2'b00;
    // Second pass overwrote selects 0..2; select 3 is never stored
    for (int i = 0; i < 8; i++) begin
      {segRdIdx, fpwRdSel} = {i[2:0], i[1:0]};
      step;
      chk("segRdData", (i < 6) ? 16'h1000 + i : 80'h0, {64'h0, segRdData});
      fpwExp = (i[1:0] == 2'h3) ? 16'h0000 : 16'ha5a4 + i[1:0];
      chk("fpwRdData", fpwExp, {64'h0, fpwRdData});
    end
    // Lone write then read with write idle, so the segment checker fires
    {segWrEn, segWrIdx, segWrData} = {1'b1, 3'h2, 16'h5a5a};
    step;
    {segWrEn, segRdIdx} = {1'b0, 3'h2};
    step;
    chk("segRdData", 16'h5a5a, {64'h0, segRdData});
  endtask
  task test_fp;
    {fpWrEn, fpWrIdx, fpWrData} = {1'b1, 3'h4, 80'h4001_0123_4567_89ab_cdef};
    {mmWrEn, mmWrIdx, mmWrData} = {1'b1, 3'h3, 64'hcafe_f00d_1234_5678};
    step;
    // Both writes aim at one register; the multimedia one must win
    {fpWrIdx, mmWrIdx} = {3'h5, 3'h5};
    step;
    {fpWrEn, mmWrEn, fpRdIdx} = {2'b00, 3'h4};
    step;
    chk("fpRdData", 80'h4001_0123_4567_89ab_cdef, fpRdData);
    fpRdIdx = 3'h3;
    step;
    chk("fpRdData", 80'hffff_cafe_f00d_1234_5678, fpRdData);
    chk("mmRdData", 64'hcafe_f00d_1234_5678, {16'h0, mmRdData});
    fpRdIdx = 3'h5;
    step;
    chk("fpRdData", 80'hffff_cafe_f00d_1234_5678, fpRdData);
  endtask
  // Model starts at 0x1fff8, so the upper half is live in both modes
  task test_ip;
    {run, mode16} = 2'b10;
    repeat (3) step;
    run = 0;
    repeat (3) step;
    chk("instrPointerWide", 32'h00020004, {48'h0, instrPointerWide});
    {run, mode16} = 2'b11;
    repeat (3) step;
    run = 0;
    repeat (3) step;
    chk("instrPointerWide", 32'h00000010, {48'h0, instrPointerWide});
    chk("instrPointerNarrow", 16'h0010, {64'h0, instrPointerNarrow});
  endtask
  task complete_run;
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    #1 rst_b = 1;
    test_gpr;
    test_words;
    test_fp;
    test_ip;
    complete_run;
  end
endmodule
bind xarf_register_file xarf_checker u_chk (.clock, .rst_b, .ipLoadEn, .ipNext, .ipMode16,
  .instrPointerWide, .instrPointerNarrow, .segWrEn, .segWrIdx, .segWrData, .segRdIdx,
  .segRdData, .fpwRdSel, .fpwRdData, .fpRdData, .mmRdData, .gprRdIdx, .gprRdSize, .gprRdData);
